// ===== include/trc_map.svh
// Constants of the telemetry readback and channel options block.
// Included by every design file of the block; holds definitions only.
`ifndef TRC_MAP_SVH
`define TRC_MAP_SVH

// Command codes seen on the command port.
`define TRC_CMD_READ_VIN     8'h88
`define TRC_CMD_READ_VOUT    8'h8B
`define TRC_CMD_READ_TEMP    8'h8D
`define TRC_CMD_PROTO_REV    8'h98
`define TRC_CMD_CHAN_OPTS    8'hD0

// Fixed protocol revision answer.
`define TRC_PROTO_REV_VALUE  8'h11

// Channel options word: reset value and writable bits.
`define TRC_OPTS_RESET       16'h0000
`define TRC_OPTS_WMASK       16'hCFFF

// Field positions inside the channel options word.
`define TRC_OPTS_MODE_HI     15
`define TRC_OPTS_MODE_LO     14
`define TRC_OPTS_FAST_OFF    11
`define TRC_OPTS_SUP_RES     10
`define TRC_OPTS_ADC_HIRES   9
`define TRC_OPTS_CTRL_SEL    8
`define TRC_OPTS_SERVO_CONT  7
`define TRC_OPTS_SERVO_WARN  6
`define TRC_OPTS_DAC_HI      5
`define TRC_OPTS_DAC_LO      4

`endif

// ===== include/trc_pkg.sv
// Types shared by the telemetry readback and channel options block.
// Needs no other file; compiled before the interface and the modules.
package trc_pkg;

  // Source of an ADC result handed to the block.
  typedef enum logic [1:0] {
    TRC_SRC_VIN  = 2'h0,
    TRC_SRC_VOUT = 2'h1,
    TRC_SRC_TEMP = 2'h2,
    TRC_SRC_NONE = 2'h3
  } trc_src_t;

  // Channel sequencing mode field.
  typedef enum logic [1:0] {
    TRC_MODE_SEQ_IMM = 2'h0,
    TRC_MODE_SEQ_OFF = 2'h1,
    TRC_MODE_TRACK_A = 2'h2,
    TRC_MODE_TRACK_B = 2'h3
  } trc_chan_mode_t;

  // DAC usage field.
  typedef enum logic [1:0] {
    TRC_DAC_SERVO  = 2'h0,
    TRC_DAC_OFF    = 2'h1,
    TRC_DAC_STORED = 2'h2,
    TRC_DAC_SOFT   = 2'h3
  } trc_dac_mode_t;

endpackage

// ===== include/trc_if.sv
// Carrier between the top of the block and its two storage modules.
// Assumes a single clock domain; all signals change on the top's clock.
`timescale 1ns/1ps
interface trc_if #(
  parameter int NCH = 8
);
  localparam int PW = $clog2(NCH);

  // Channel options write strobe and the stored words.
  logic                  opts_wr;
  logic [PW-1:0]         opts_page;
  logic [15:0]           opts_wdata;
  logic [NCH-1:0][15:0]  opts_word;

  // ADC result delivery.
  logic                  adc_valid;
  trc_pkg::trc_src_t     adc_src;
  logic [PW-1:0]         adc_chan;
  logic [15:0]           adc_data;

  // Latest finished readings.
  logic [15:0]           vin_word;
  logic [15:0]           temp_word;
  logic [NCH-1:0][15:0]  vout_word;
  logic [NCH-1:0]        vout_l11;

  modport bank_mp (
    input  opts_wr, opts_page, opts_wdata,
    output opts_word
  );

  modport snap_mp (
    input  adc_valid, adc_src, adc_chan, adc_data, opts_word,
    output vin_word, temp_word, vout_word, vout_l11
  );
endinterface

// ===== design/trc_opts_bank.sv
// Per-channel storage of the channel options word.
// Assumes the top decodes the write and presents the current page.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_opts_bank #(
  parameter int NCH = 8
) (
  // Clock and reset.
  input  wire logic  i_clk_sys,
  input  wire logic  i_nrst,
  // Carrier to the top.
  trc_if.bank_mp     bus
);
  import trc_pkg::*;

  logic [NCH-1:0][15:0] opts_reg;

  // One word per channel, written only when its page is selected.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_word
      // Reserved bits are masked away so they always read as zero.
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          opts_reg[g] <= `TRC_OPTS_RESET;
        end else if (bus.opts_wr && (int'(bus.opts_page) == g)) begin // [R6]
          opts_reg[g] <= bus.opts_wdata & `TRC_OPTS_WMASK; // [R8]
        end
      end
    end
  endgenerate

  assign bus.opts_word = opts_reg;

endmodule

// ===== design/trc_tlm_snap.sv
// Latest ADC readings, each kept as one whole word.
// Assumes ADC results arrive from logic on the same clock.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_tlm_snap #(
  parameter int NCH = 8
) (
  // Clock and reset.
  input  wire logic  i_clk_sys,
  input  wire logic  i_nrst,
  // Carrier to the top.
  trc_if.snap_mp     bus
);
  import trc_pkg::*;

  logic [15:0]          vin_reg;
  logic [15:0]          temp_reg;
  logic [NCH-1:0][15:0] vout_reg;
  logic [NCH-1:0]       l11_reg;

  // Input voltage and die temperature replace their word in one edge.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      vin_reg  <= 16'h0000;
      temp_reg <= 16'h0000;
    end else if (bus.adc_valid) begin
      if (bus.adc_src == TRC_SRC_VIN) begin
        vin_reg <= bus.adc_data; // [R1] [R16]
      end
      if (bus.adc_src == TRC_SRC_TEMP) begin
        temp_reg <= bus.adc_data; // [R4] [R16]
      end
    end
  end

  // Output readings; the format tag is fixed at conversion time so a
  // later change of resolution cannot mislabel an old sample.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_vout
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          vout_reg[g] <= 16'h0000;
          l11_reg[g]  <= 1'b0;
        end else if (bus.adc_valid && (bus.adc_src == TRC_SRC_VOUT) &&
                     (int'(bus.adc_chan) == g)) begin
          vout_reg[g] <= bus.adc_data; // [R2] [R16]
          l11_reg[g]  <= ((g % 2) == 1) &&
                         bus.opts_word[g][`TRC_OPTS_ADC_HIRES]; // [R3]
        end
      end
    end
  endgenerate

  assign bus.vin_word  = vin_reg;
  assign bus.temp_word = temp_reg;
  assign bus.vout_word = vout_reg;
  assign bus.vout_l11  = l11_reg;

endmodule

// ===== design/trc_top.sv
// Telemetry readback and per-channel options for an eight-channel
// supply manager, sitting behind the serial protocol engine.
// Assumes the protocol engine decodes frames and presents one command
// at a time, with the current page, on the system clock.
//
// Operation
// R1 - Input voltage read returns latest L11 volts.
// R2 - Output read returns latest L16 volts word.
// R3 - Odd hires channel returns L11 millivolts instead.
// R4 - Temperature read returns latest L11 Celsius word.
// R5 - Revision is read-only, always 0x11.
// R6 - Options word kept separately per page.
// R7 - Mode field: immediate off, sequenced off, tracking.
// R8 - Reserved option bits ignored, read zero.
// R9 - Bit 11 set disables fast servo.
// R10 - Bit 10 picks 4 mV or 8 mV supervisor.
// R11 - Bit 9 fine ADC, odd channels only.
// R12 - Bit 8 picks control pin zero or one.
// R13 - Bit 7 continuous servo, only DAC mode 00.
// R14 - Bit 6 re-servo on warning, restricted.
// R15 - DAC field selects connect behaviour after rise.
// R16 - Each read returns one whole conversion word.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_top #(
  parameter int NCH = 8,
  parameter int PW  = 3
) (
  // Clock and reset.
  input  wire logic               i_clk_sys,
  input  wire logic               i_nrst,
  // Command port from the protocol engine.
  input  wire logic               i_cmd_valid,
  input  wire logic               i_cmd_write,
  input  wire logic [7:0]         i_cmd_code,
  input  wire logic [15:0]        i_cmd_wdata,
  input  wire logic [PW-1:0]      i_page,
  // Command answer.
  output logic                    o_rsp_valid,
  output logic [15:0]             o_rsp_data,
  output logic                    o_rsp_l11,
  output logic                    o_rsp_err,
  // ADC results from the conversion sequencer.
  input  wire logic               i_adc_valid,
  input  wire trc_pkg::trc_src_t  i_adc_src,
  input  wire logic [PW-1:0]      i_adc_chan,
  input  wire logic [15:0]        i_adc_data,
  // Control pins and channel state.
  input  wire logic               i_control_pin_zero,
  input  wire logic               i_control_pin_one,
  input  wire logic [NCH-1:0]     i_rise_done,
  // Sequencing and supervision settings per channel.
  output logic [NCH-1:0]          o_track_slave,
  output logic [NCH-1:0]          o_seq_off_on_fault,
  output logic [NCH-1:0]          o_fast_servo_en,
  output logic [NCH-1:0]          o_sup_res_8mv,
  output logic [NCH-1:0]          o_adc_fine,
  output logic [NCH-1:0]          o_chan_control,
  // Servo and DAC behaviour per channel.
  output logic [NCH-1:0]          o_servo_continuous,
  output logic [NCH-1:0]          o_servo_on_warn,
  output logic [NCH-1:0]          o_dac_soft_servo,
  output logic [NCH-1:0]          o_dac_detached,
  output logic [NCH-1:0]          o_dac_use_stored,
  output logic [NCH-1:0]          o_dac_soft_only
);
  import trc_pkg::*;

  // DAC usage field of an options word.
  function automatic trc_dac_mode_t dac_mode_of(input logic [15:0] w);
    dac_mode_of = trc_dac_mode_t'(w[`TRC_OPTS_DAC_HI:`TRC_OPTS_DAC_LO]);
  endfunction

  // Sequencing mode field of an options word.
  function automatic trc_chan_mode_t chan_mode_of(input logic [15:0] w);
    chan_mode_of =
      trc_chan_mode_t'(w[`TRC_OPTS_MODE_HI:`TRC_OPTS_MODE_LO]);
  endfunction

  trc_if #(.NCH(NCH)) u_if ();

  // Storage of the options words.
  trc_opts_bank #(
    .NCH (NCH)
  ) u_bank (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .bus       (u_if.bank_mp)
  );

  // Storage of the latest readings.
  trc_tlm_snap #(
    .NCH (NCH)
  ) u_snap (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .bus       (u_if.snap_mp)
  );

  // Command decode.
  wire hit_vin   = (i_cmd_code == `TRC_CMD_READ_VIN);
  wire hit_vout  = (i_cmd_code == `TRC_CMD_READ_VOUT);
  wire hit_temp  = (i_cmd_code == `TRC_CMD_READ_TEMP);
  wire hit_rev   = (i_cmd_code == `TRC_CMD_PROTO_REV);
  wire hit_opts  = (i_cmd_code == `TRC_CMD_CHAN_OPTS);
  wire hit_any   = hit_vin | hit_vout | hit_temp | hit_rev | hit_opts;

  // Only the options word accepts writes; the revision never changes.
  wire wr_ok     = i_cmd_write & hit_opts; // [R5]
  wire cmd_err   = i_cmd_write ? ~wr_ok : ~hit_any;

  // Routing of the write to the per-page storage.
  assign u_if.opts_wr    = i_cmd_valid & wr_ok; // [R6]
  assign u_if.opts_page  = i_page;
  assign u_if.opts_wdata = i_cmd_wdata;

  // ADC results pass straight through to the reading store.
  assign u_if.adc_valid  = i_adc_valid;
  assign u_if.adc_src    = i_adc_src;
  assign u_if.adc_chan   = i_adc_chan;
  assign u_if.adc_data   = i_adc_data;

  // Read data selection; every source is a whole word, stored or, for the revision, fixed.
  wire [15:0] rev_word   = {8'h00, `TRC_PROTO_REV_VALUE}; // [R5]
  wire [15:0] page_opts  = u_if.opts_word[i_page];
  wire [15:0] page_vout  = u_if.vout_word[i_page];
  wire [15:0] rd_word    =
    hit_vin  ? u_if.vin_word  : // [R1]
    hit_vout ? page_vout      : // [R2]
    hit_temp ? u_if.temp_word : // [R4]
    hit_rev  ? rev_word       :
    hit_opts ? page_opts      : 16'h0000;

  // Format tag: L11 for input voltage, temperature and fine odd outputs.
  wire rd_l11 = hit_vin | hit_temp |
                (hit_vout & u_if.vout_l11[i_page]); // [R3]

  logic        rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic        rsp_l11_reg;
  logic        rsp_err_reg;

  // Answer one cycle after each command; the word is taken in a single
  // edge so a conversion finishing meanwhile cannot split it.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
      rsp_l11_reg   <= 1'b0;
      rsp_err_reg   <= 1'b0;
    end else begin
      rsp_valid_reg <= i_cmd_valid;
      if (i_cmd_valid) begin
        rsp_data_reg <= (i_cmd_write | cmd_err) ? 16'h0000 : rd_word; // [R16]
        rsp_l11_reg  <= ~i_cmd_write & ~cmd_err & rd_l11;
        rsp_err_reg  <= cmd_err;
      end
    end
  end

  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_data  = rsp_data_reg;
  assign o_rsp_l11   = rsp_l11_reg;
  assign o_rsp_err   = rsp_err_reg;

  // Control pins come from outside, so each passes two flip-flops.
  logic [1:0] ctl_meta_reg;
  logic [1:0] ctl_sync_reg;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_meta_reg <= 2'h0;
      ctl_sync_reg <= 2'h0;
    end else begin
      ctl_meta_reg <= {i_control_pin_one, i_control_pin_zero};
      ctl_sync_reg <= ctl_meta_reg;
    end
  end

  // Per-channel decoding of the options word into registered outputs.
  logic [NCH-1:0] track_reg;
  logic [NCH-1:0] seqoff_reg;
  logic [NCH-1:0] fast_reg;
  logic [NCH-1:0] sup_reg;
  logic [NCH-1:0] fine_reg;
  logic [NCH-1:0] ctrl_reg;
  logic [NCH-1:0] cont_reg;
  logic [NCH-1:0] warn_reg;
  logic [NCH-1:0] dservo_reg;
  logic [NCH-1:0] ddet_reg;
  logic [NCH-1:0] dstore_reg;
  logic [NCH-1:0] dsoft_reg;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      wire [15:0]      w     = u_if.opts_word[g];
      trc_chan_mode_t  cmode;
      trc_dac_mode_t   dmode;
      assign cmode = chan_mode_of(w);
      assign dmode = dac_mode_of(w);

      // Mode field: upper bit alone makes a tracking slave.
      wire track_n  = (cmode == TRC_MODE_TRACK_A) |
                      (cmode == TRC_MODE_TRACK_B); // [R7]
      wire seqoff_n = (cmode == TRC_MODE_SEQ_OFF); // [R7]
      // Fast servo runs unless its disable bit is set.
      wire fast_n   = ~w[`TRC_OPTS_FAST_OFF]; // [R9]
      // Set selects the coarse 8 mV step and the wider range.
      wire sup_n    = w[`TRC_OPTS_SUP_RES]; // [R10]
      // Even channels always stay on the coarse ADC step.
      wire fine_n   = ((g % 2) == 1) & w[`TRC_OPTS_ADC_HIRES]; // [R11]
      // Channel follows whichever control pin its select bit names.
      wire ctrl_n   = w[`TRC_OPTS_CTRL_SEL] ? ctl_sync_reg[1] :
                                              ctl_sync_reg[0]; // [R12]
      wire servo_n  = (dmode == TRC_DAC_SERVO);
      wire cont_n   = servo_n & w[`TRC_OPTS_SERVO_CONT]; // [R13]
      wire warn_n   = servo_n & ~w[`TRC_OPTS_SERVO_CONT] &
                      w[`TRC_OPTS_SERVO_WARN]; // [R14]
      // DAC behaviour applies only once the channel is on and risen.
      wire rise_n   = i_rise_done[g];
      wire dservo_n = rise_n & (dmode == TRC_DAC_SERVO); // [R15]
      wire ddet_n   = rise_n & (dmode == TRC_DAC_OFF); // [R15]
      wire dstore_n = rise_n & (dmode == TRC_DAC_STORED); // [R15]
      wire dsoft_n  = rise_n & (dmode == TRC_DAC_SOFT); // [R15]

      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          track_reg[g]  <= 1'b0;
          seqoff_reg[g] <= 1'b0;
          fast_reg[g]   <= 1'b0;
          sup_reg[g]    <= 1'b0;
          fine_reg[g]   <= 1'b0;
          ctrl_reg[g]   <= 1'b0;
        end else begin
          track_reg[g]  <= track_n;
          seqoff_reg[g] <= seqoff_n;
          fast_reg[g]   <= fast_n;
          sup_reg[g]    <= sup_n;
          fine_reg[g]   <= fine_n;
          ctrl_reg[g]   <= ctrl_n;
        end
      end

      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          cont_reg[g]   <= 1'b0;
          warn_reg[g]   <= 1'b0;
          dservo_reg[g] <= 1'b0;
          ddet_reg[g]   <= 1'b0;
          dstore_reg[g] <= 1'b0;
          dsoft_reg[g]  <= 1'b0;
        end else begin
          cont_reg[g]   <= cont_n;
          warn_reg[g]   <= warn_n;
          dservo_reg[g] <= dservo_n;
          ddet_reg[g]   <= ddet_n;
          dstore_reg[g] <= dstore_n;
          dsoft_reg[g]  <= dsoft_n;
        end
      end
    end
  endgenerate

  // Registered per-channel outputs.
  assign o_track_slave      = track_reg;
  assign o_seq_off_on_fault = seqoff_reg;
  assign o_fast_servo_en    = fast_reg;
  assign o_sup_res_8mv      = sup_reg;
  assign o_adc_fine         = fine_reg;
  assign o_chan_control     = ctrl_reg;
  assign o_servo_continuous = cont_reg;
  assign o_servo_on_warn    = warn_reg;
  assign o_dac_soft_servo   = dservo_reg;
  assign o_dac_detached     = ddet_reg;
  assign o_dac_use_stored   = dstore_reg;
  assign o_dac_soft_only    = dsoft_reg;

endmodule

// ===== test/trc_top_checker.sv
// Concurrent checks on the ports of the telemetry and options block.
// Assumes one clock domain; bound to every instance of trc_top.
`timescale 1ns/1ps
`include "trc_map.svh"
module trc_top_checker #(
  parameter int NCH = 8,
  parameter int PW  = 3
) (
  // Clock and reset.
  input wire logic           i_clk_sys,
  input wire logic           i_nrst,
  // Command port and answer.
  input wire logic           i_cmd_valid,
  input wire logic           i_cmd_write,
  input wire logic [7:0]     i_cmd_code,
  input wire logic [PW-1:0]  i_page,
  input wire logic           o_rsp_valid,
  input wire logic [15:0]    o_rsp_data,
  input wire logic           o_rsp_l11,
  input wire logic           o_rsp_err,
  // Channel state and decoded settings.
  input wire logic [NCH-1:0] i_rise_done,
  input wire logic [NCH-1:0] o_track_slave,
  input wire logic [NCH-1:0] o_seq_off_on_fault,
  input wire logic [NCH-1:0] o_adc_fine,
  input wire logic [NCH-1:0] o_servo_continuous,
  input wire logic [NCH-1:0] o_servo_on_warn,
  input wire logic [NCH-1:0] o_dac_soft_servo,
  input wire logic [NCH-1:0] o_dac_detached,
  input wire logic [NCH-1:0] o_dac_use_stored,
  input wire logic [NCH-1:0] o_dac_soft_only
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  // Read strobe and union of the DAC usage decodes.
  wire           rd_cmd = i_cmd_valid && !i_cmd_write;
  wire [NCH-1:0] dac_any = o_dac_soft_servo | o_dac_detached |
                           o_dac_use_stored | o_dac_soft_only;

  a_answer_next: assert property (i_cmd_valid |=> o_rsp_valid)
    else $error("answer missing after command");
  a_answer_caused: assert property (o_rsp_valid |-> $past(i_cmd_valid))
    else $error("answer without command");
  a_revision_fixed: assert property (
    rd_cmd && i_cmd_code == `TRC_CMD_PROTO_REV
    |=> o_rsp_data == 16'h0011 && !o_rsp_err)
    else $error("revision answer wrong");
  a_readonly_refused: assert property (
    i_cmd_valid && i_cmd_write && i_cmd_code != `TRC_CMD_CHAN_OPTS
    |=> o_rsp_err && o_rsp_data == 16'h0000)
    else $error("write to read-only code taken");
  a_reserved_zero: assert property (
    rd_cmd && i_cmd_code == `TRC_CMD_CHAN_OPTS
    |=> o_rsp_data[13:12] == 2'h0 && !o_rsp_err)
    else $error("reserved option bits read nonzero");
  a_vin_l11: assert property (
    rd_cmd && i_cmd_code == `TRC_CMD_READ_VIN |=> o_rsp_l11)
    else $error("input reading not tagged L11");
  a_temp_l11: assert property (
    rd_cmd && i_cmd_code == `TRC_CMD_READ_TEMP |=> o_rsp_l11)
    else $error("temperature reading not tagged L11");
  a_even_vout_l16: assert property (
    rd_cmd && i_cmd_code == `TRC_CMD_READ_VOUT && !i_page[0]
    |=> !o_rsp_l11 && !o_rsp_err)
    else $error("even channel output not L16");
  a_even_coarse: assert property ((o_adc_fine & 8'h55) == 8'h00)
    else $error("fine resolution on even channel");
  a_mode_exclusive: assert property (
    (o_track_slave & o_seq_off_on_fault) == '0)
    else $error("tracking and sequenced off together");
  a_warn_exclusive: assert property (
    (o_servo_on_warn & o_servo_continuous) == '0)
    else $error("re-servo on warning with continuous servo");
  a_dac_after_rise: assert property (
    $past(i_nrst) |-> dac_any == $past(i_rise_done))
    else $error("DAC usage not tied to rise done");
endmodule

bind trc_top trc_top_checker #(.NCH(NCH), .PW(PW)) u_trc_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
  .i_cmd_write(i_cmd_write), .i_cmd_code(i_cmd_code), .i_page(i_page),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
  .o_rsp_l11(o_rsp_l11), .o_rsp_err(o_rsp_err),
  .i_rise_done(i_rise_done), .o_track_slave(o_track_slave),
  .o_seq_off_on_fault(o_seq_off_on_fault), .o_adc_fine(o_adc_fine),
  .o_servo_continuous(o_servo_continuous),
  .o_servo_on_warn(o_servo_on_warn),
  .o_dac_soft_servo(o_dac_soft_servo), .o_dac_detached(o_dac_detached),
  .o_dac_use_stored(o_dac_use_stored), .o_dac_soft_only(o_dac_soft_only)
);

// ===== test/trc_host_model.sv
// Host model: issues one command at a time on the command port.
// Assumes the answer is registered on the taking edge and read half a clock later.
`timescale 1ns/1ps
module trc_host_model (
  // Clock.
  input  wire logic        i_clk_sys,
  // Command port towards the block.
  output logic             o_cmd_valid,
  output logic             o_cmd_write,
  output logic [7:0]       o_cmd_code,
  output logic [15:0]      o_cmd_wdata,
  output logic [2:0]       o_page,
  // Answer from the block.
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_rsp_l11,
  input  wire logic        i_rsp_err
);
  // Idle port at time zero.
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_wdata = 16'h0000;
    o_page = 3'h0;
  end

  // One command; the lines show the inverse once let go, not a stale copy.
  task automatic cmd(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [2:0] p,
                     output logic [15:0] rd, output logic rl,
                     output logic re, output logic seen);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'b1;
    o_cmd_write = w;
    o_cmd_code = c;
    o_cmd_wdata = d;
    o_page = p;
    @(negedge i_clk_sys);
    // The answer strobe stands for one cycle only, so take it now.
    seen = i_rsp_valid;
    rd = i_rsp_data;
    rl = i_rsp_l11;
    re = i_rsp_err;
    o_cmd_valid = 1'b0;
    o_cmd_write = ~w;
    o_cmd_code = ~c;
    o_cmd_wdata = ~d;
    o_page = ~p;
  endtask
endmodule

// ===== test/telemetry_readback_and_channel_config_test.sv
// Self-checking bench for the telemetry and options block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`include "trc_map.svh"
module telemetry_readback_and_channel_config_test;
  import trc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, av = 1'b0, p0 = 1'b0, p1 = 1'b0;
  logic cv, cw, rv, rl, re, l, e, s;
  trc_src_t asrc = TRC_SRC_NONE;
  logic [2:0] ach = 3'h0, page;
  logic [7:0] code, rise = 8'h00;
  logic [15:0] ad = 16'h0000, wd, rdat, rd, v;
  logic [7:0] trk, seq, fst, sup, fin, ctl, scn, swn, dss, ddt, dus, dso;
  logic [15:0] opts [8];
  logic [15:0] corner [5] = '{16'hFFFF, 16'h4040, 16'h8020, 16'h0250,
                              16'h10C0};
  int err_total = 0, total_checks = 0, cyc = 0;

  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end

  trc_top dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_cmd_valid(cv), .i_cmd_write(cw),
    .i_cmd_code(code), .i_cmd_wdata(wd), .i_page(page),
    .o_rsp_valid(rv), .o_rsp_data(rdat), .o_rsp_l11(rl), .o_rsp_err(re),
    .i_adc_valid(av), .i_adc_src(asrc), .i_adc_chan(ach), .i_adc_data(ad),
    .i_control_pin_zero(p0), .i_control_pin_one(p1), .i_rise_done(rise),
    .o_track_slave(trk), .o_seq_off_on_fault(seq), .o_fast_servo_en(fst),
    .o_sup_res_8mv(sup), .o_adc_fine(fin), .o_chan_control(ctl),
    .o_servo_continuous(scn), .o_servo_on_warn(swn),
    .o_dac_soft_servo(dss), .o_dac_detached(ddt),
    .o_dac_use_stored(dus), .o_dac_soft_only(dso)
  );

  trc_host_model host (
    .i_clk_sys(clk), .o_cmd_valid(cv), .o_cmd_write(cw), .o_cmd_code(code),
    .o_cmd_wdata(wd), .o_page(page), .i_rsp_valid(rv), .i_rsp_data(rdat),
    .i_rsp_l11(rl), .i_rsp_err(re)
  );

  // Compares one value and counts the outcome.
  task automatic check(string name, logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Issues a command and checks that it was answered.
  task automatic run(logic w, logic [7:0] c, logic [15:0] d, logic [2:0] p);
    host.cmd(w, c, d, p, rd, l, e, s);
    check("rsp_valid", {15'h0, s}, 16'h0001);
  endtask

  // Hands one ADC result to the block for a single cycle.
  task automatic adc(trc_src_t sr, logic [2:0] c, logic [15:0] d);
    @(negedge clk);
    av = 1'b1;
    asrc = sr;
    ach = c;
    ad = d;
    @(negedge clk);
    av = 1'b0;
  endtask

  // Expected per-channel settings for one options word.
  function automatic logic [11:0] expect_ch(logic [15:0] w, int c);
    logic dz;
    dz = (w[5:4] == 2'h0);
    return {w[15], w[15:14] == 2'h1, ~w[11], w[10], w[9] & c[0],
            w[8] ? p1 : p0, w[7] & dz, w[6] & ~w[7] & dz,
            rise[c] & dz, rise[c] & (w[5:4] == 2'h1),
            rise[c] & (w[5:4] == 2'h2), rise[c] & (w[5:4] == 2'h3)};
  endfunction

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(44));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check("fast_en", {8'h00, fst}, 16'h00FF);
    run(1'b0, `TRC_CMD_PROTO_REV, 16'h0000, 3'h5);
    check("rev", rd, 16'h0011);
    run(1'b1, `TRC_CMD_PROTO_REV, 16'h00AA, 3'h0);
    check("rev_wr_err", {15'h0, e}, 16'h0001);
    run(1'b0, `TRC_CMD_PROTO_REV, 16'h0000, 3'h0);
    check("rev_kept", rd, 16'h0011);
    run(1'b0, 8'h00, 16'h0000, 3'h0);
    check("unknown_err", {15'h0, e}, 16'h0001);
    for (int p = 0; p < 8; p++) begin
      opts[p] = (p < 5) ? corner[p] : 16'($urandom);
      run(1'b1, `TRC_CMD_CHAN_OPTS, opts[p], 3'(p));
      check("wr_err", {15'h0, e}, 16'h0000);
    end
    for (int p = 0; p < 8; p++) begin
      run(1'b0, `TRC_CMD_CHAN_OPTS, 16'h0000, 3'(p));
      check("opts", rd, opts[p] & 16'hCFFF);
    end
    repeat (3) begin
      @(negedge clk);
      {p1, p0} = 2'($urandom);
      rise = 8'($urandom);
      repeat (4) @(negedge clk);
      for (int c = 0; c < 8; c++) begin
        v = {4'h0, expect_ch(opts[c], c)};
        check("ch_cfg", {10'h0, trk[c], seq[c], fst[c], sup[c], fin[c],
              ctl[c]}, {10'h0, v[11:6]});
        check("ch_dac", {10'h0, scn[c], swn[c], dss[c], ddt[c], dus[c],
              dso[c]}, {10'h0, v[5:0]});
      end
    end
    v = 16'($urandom);
    adc(TRC_SRC_TEMP, 3'h0, ~v);
    run(1'b0, `TRC_CMD_READ_TEMP, 16'h0000, 3'h0);
    check("temp", rd, ~v);
    check("temp_l11", {15'h0, l}, 16'h0001);
    adc(TRC_SRC_VIN, 3'h0, v);
    run(1'b0, `TRC_CMD_READ_VIN, 16'h0000, 3'h0);
    check("vin", rd, v);
    check("vin_l11", {15'h0, l}, 16'h0001);
    fork
      adc(TRC_SRC_VIN, 3'h0, ~v);
      run(1'b0, `TRC_CMD_READ_VIN, 16'h0000, 3'h0);
    join
    check("vin_prev", rd, v);
    run(1'b0, `TRC_CMD_READ_VIN, 16'h0000, 3'h0);
    check("vin_new", rd, ~v);
    for (int c = 0; c < 8; c++) begin
      v = 16'($urandom);
      adc(TRC_SRC_VOUT, 3'(c), v);
      run(1'b0, `TRC_CMD_READ_VOUT, 16'h0000, 3'(c));
      check("vout", rd, v);
      check("vout_l11", {15'h0, l}, {15'h0, c[0] & opts[c][9]});
    end
    final_report();
  end
endmodule
